// ===== hdl/sensor_sync.sv
// three-stage synchroniser with agreement filter for discrete inputs
`timescale 1ns/1ns
module sensor_sync
	import stepper_regs_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// pins and filtered levels
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] levels_ff
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff     <= '0;
			s2_ff     <= '0;
			s3_ff     <= '0;
			levels_ff <= '0;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			// only bits where stages two and three agree may move
			levels_ff <= (levels_ff & ~(s2_ff ~^ s3_ff)) | (s2_ff & (s2_ff ~^ s3_ff));
		end
	end
endmodule

// ===== hdl/speed_limiter.sv
// clamps the commanded speed to the window allowed by the resolution while morphing, else to the fixed window
`timescale 1ns/1ns
module speed_limiter
	import stepper_regs_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// speed request and answer
	speed_if.limiter  spd
);
	logic [31:0] max_pps;

	// upper limit scales with resolution only while morphing
	assign max_pps = spd.morph_en ? (SPEED_MAX_PPS << spd.res_code) : SPEED_MAX_PPS;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spd.lim_pps_ff  <= SPEED_MIN_PPS;
			spd.too_slow_ff <= 1'b0;
			spd.too_fast_ff <= 1'b0;
		end else begin
			spd.too_slow_ff <= spd.req_pps < SPEED_MIN_PPS;
			spd.too_fast_ff <= spd.req_pps > max_pps;
			if (spd.req_pps < SPEED_MIN_PPS)
				spd.lim_pps_ff <= SPEED_MIN_PPS;
			else if (spd.req_pps > max_pps)
				spd.lim_pps_ff <= max_pps;
			else
				spd.lim_pps_ff <= spd.req_pps;
		end
	end

	// limited speed never leaves the window
	chk_speed_window: assert property (@(posedge clk) disable iff (!rst_n)
		spd.lim_pps_ff >= SPEED_MIN_PPS && spd.lim_pps_ff <= (SPEED_MAX_PPS << 8))
		else $error("limited speed outside window");
	cover_speed_clamp_high: cover property (@(posedge clk) disable iff (!rst_n)
		spd.too_fast_ff);
endmodule

// ===== hdl/stepper_param_regs.sv
// parameter and status registers of the stepper driver
// Function
// - rotor microstep phase is a 16-bit read-only register within four full steps.
// - resolution codes 0-5,7,8 give divisions 1/1 to 1/256 and code 6 is invalid.
// - rotation sense 1 commands forward and 0 backward.
// - a 32-bit full-step switch threshold in full steps per second is held.
// - with morphing on, full-step mode starts once speed reaches the threshold.
// - with morphing off, microstepping stays at all speeds and torque boost is off.
// - a 32-bit goal position in microsteps is held.
// - a 16-bit motion order code selects the movement to perform.
// - a limit sensor selection 0 to 7 names the watched discrete input.
// - acceleration phase current is in mA within 150 to 1500.
// - deceleration phase current is in mA within 150 to 1500.
// - cruise phase current is in mA within 150 to 1500.
// - an invalid resolution write reports a data error.
// - commanded speed is limited to 8 pps up to 120000, scaled by resolution when morphing.
`timescale 1ns/1ns
module stepper_param_regs
	import stepper_regs_pkg::*;
#(
	parameter int SENSORS = 8
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// register access, coil qualifies a single-bit access
	input  wire logic [15:0]        reg_addr,
	input  wire logic               reg_coil,
	input  wire logic               reg_wr,
	input  wire logic [15:0]        reg_wdata,
	input  wire logic               reg_rd,
	output logic      [15:0]        reg_rdata_ff,
	output logic                    reg_rvalid_ff,
	output logic                    reg_addr_err_ff,
	output logic                    data_error_ff,
	// motion engine status
	input  wire logic [15:0]        rotor_phase_in,
	input  wire logic [31:0]        speed_fs_in,
	input  wire logic [31:0]        speed_req_in,
	input  wire logic [1:0]         motion_phase_in,
	// motion engine configuration
	output logic      [3:0]         resolution_ff,
	output logic                    forward_ff,
	output logic      [31:0]        fs_threshold_ff,
	output logic                    fullstep_mode_ff,
	output logic                    torque_boost_ff,
	output logic      [31:0]        goal_pos_ff,
	output logic      [15:0]        motion_order_ff,
	output logic      [2:0]         sensor_sel_ff,
	output logic      [15:0]        phase_current_ff,
	output logic      [31:0]        speed_lim_pps,
	output logic                    speed_too_slow,
	output logic                    speed_too_fast,
	// limit sensors
	input  wire logic [SENSORS-1:0] sensor_pins,
	output logic                    sensor_level_ff
);
	logic [1:0]         rst_sync_ff;
	logic               rst_n_i;
	logic [15:0]        sense_ff;
	logic [15:0]        morph_ff;
	logic [15:0]        res_reg_ff;
	logic [15:0]        sensor_reg_ff;
	logic [15:0]        accel_cur_ff;
	logic [15:0]        decel_cur_ff;
	logic [15:0]        cruise_cur_ff;
	logic [SENSORS-1:0] sensor_levels;
	logic               wr_word;
	logic               wr_bit;
	logic               res_ok;
	logic               cur_ok;
	logic               sensor_ok;
	logic               bad_write;
	logic [15:0]        nxt_rdata;
	logic               nxt_addr_err;

	speed_if spd ();

	// reset released through two flops so every block leaves reset together
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n_i = rst_sync_ff[1];

	assign wr_word = reg_wr && !reg_coil;
	assign wr_bit  = reg_wr && reg_coil;

	// code 6 and anything above 8 is refused
	assign res_ok    = (reg_wdata <= RES_MAX) && (reg_wdata != RES_INVALID);
	assign cur_ok    = (reg_wdata >= CUR_MIN_MA) && (reg_wdata <= CUR_MAX_MA);
	assign sensor_ok = reg_wdata <= SENSOR_MAX;

	// resolution keeps its old code on a refused write
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			res_reg_ff <= RST_RESOLUTION;
		else if (wr_word && reg_addr == ADDR_RESOLUTION && res_ok)
			res_reg_ff <= reg_wdata;
	end
	assign resolution_ff = res_reg_ff[3:0];

	// rotation sense, word and coil views share one register
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			sense_ff <= RST_SENSE;
		else if (wr_word && reg_addr == ADDR_SENSE)
			sense_ff <= reg_wdata;
		// coil write touches bit 0 only
		else if (wr_bit && reg_addr == ADDR_SENSE)
			sense_ff <= {sense_ff[15:1], reg_wdata[0]};
	end
	assign forward_ff = sense_ff[0];

	// threshold written a half at a time
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			fs_threshold_ff <= RST_FS_THR;
		else if (wr_word && reg_addr == ADDR_FS_THR_LO)
			fs_threshold_ff[15:0] <= reg_wdata;
		else if (wr_word && reg_addr == ADDR_FS_THR_HI)
			fs_threshold_ff[31:16] <= reg_wdata;
	end

	// morphing enable, word and coil views
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			morph_ff <= RST_MORPH;
		else if (wr_word && reg_addr == ADDR_MORPH)
			morph_ff <= reg_wdata;
		else if (wr_bit && reg_addr == ADDR_MORPH)
			morph_ff <= {morph_ff[15:1], reg_wdata[0]};
	end

	// full-step once speed reaches threshold while morphing
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fullstep_mode_ff <= 1'b0;
			torque_boost_ff  <= 1'b0;
		end else begin
			fullstep_mode_ff <= morph_ff[0] && (speed_fs_in >= fs_threshold_ff);
			torque_boost_ff  <= morph_ff[0];
		end
	end

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			goal_pos_ff <= RST_GOAL;
		else if (wr_word && reg_addr == ADDR_GOAL_LO)
			goal_pos_ff[15:0] <= reg_wdata;
		else if (wr_word && reg_addr == ADDR_GOAL_HI)
			goal_pos_ff[31:16] <= reg_wdata;
	end

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			motion_order_ff <= RST_ORDER;
		else if (wr_word && reg_addr == ADDR_ORDER)
			motion_order_ff <= reg_wdata;
	end

	// sensor selection, values above 7 refused
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			sensor_reg_ff <= RST_SENSOR_SEL;
		else if (wr_word && reg_addr == ADDR_SENSOR_SEL && sensor_ok)
			sensor_reg_ff <= reg_wdata;
	end
	assign sensor_sel_ff = sensor_reg_ff[2:0];

	// currents outside the window keep the old value
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			accel_cur_ff <= RST_CURRENT;
		else if (wr_word && reg_addr == ADDR_ACCEL_CUR && cur_ok)
			accel_cur_ff <= reg_wdata;
	end

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			decel_cur_ff <= RST_CURRENT;
		else if (wr_word && reg_addr == ADDR_DECEL_CUR && cur_ok)
			decel_cur_ff <= reg_wdata;
	end

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			cruise_cur_ff <= RST_CURRENT;
		else if (wr_word && reg_addr == ADDR_CRUISE_CUR && cur_ok)
			cruise_cur_ff <= reg_wdata;
	end

	// current handed to the power stage follows the motion phase
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			phase_current_ff <= RST_CURRENT;
		else if (motion_phase_in == PHASE_ACCEL)
			phase_current_ff <= accel_cur_ff;
		else if (motion_phase_in == PHASE_DECEL)
			phase_current_ff <= decel_cur_ff;
		else
			phase_current_ff <= cruise_cur_ff;
	end

	// refused writes raise a one-cycle data error
	assign bad_write = wr_word && (
		(reg_addr == ADDR_RESOLUTION && !res_ok) ||
		(reg_addr == ADDR_SENSOR_SEL && !sensor_ok) ||
		((reg_addr == ADDR_ACCEL_CUR || reg_addr == ADDR_DECEL_CUR ||
		  reg_addr == ADDR_CRUISE_CUR) && !cur_ok));

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			data_error_ff <= 1'b0;
		else
			data_error_ff <= bad_write;
	end

	// read mux; coil reads give bit 0 only
	always_comb begin
		nxt_rdata    = 16'h0000;
		nxt_addr_err = 1'b0;
		if (reg_coil) begin
			if (reg_addr == ADDR_SENSE)
				nxt_rdata = {15'h0000, sense_ff[0]};
			else if (reg_addr == ADDR_MORPH)
				nxt_rdata = {15'h0000, morph_ff[0]};
			else
				nxt_addr_err = 1'b1;
		end else begin
			unique case (reg_addr)
				// live rotor phase from the motion engine
				ADDR_ROTOR_PHASE: nxt_rdata = rotor_phase_in;
				ADDR_RESOLUTION:  nxt_rdata = res_reg_ff;
				ADDR_SENSE:       nxt_rdata = sense_ff;
				ADDR_FS_THR_LO:   nxt_rdata = fs_threshold_ff[15:0];
				ADDR_FS_THR_HI:   nxt_rdata = fs_threshold_ff[31:16];
				ADDR_MORPH:       nxt_rdata = morph_ff;
				ADDR_GOAL_LO:     nxt_rdata = goal_pos_ff[15:0];
				ADDR_GOAL_HI:     nxt_rdata = goal_pos_ff[31:16];
				ADDR_ORDER:       nxt_rdata = motion_order_ff;
				ADDR_SENSOR_SEL:  nxt_rdata = sensor_reg_ff;
				ADDR_ACCEL_CUR:   nxt_rdata = accel_cur_ff;
				ADDR_DECEL_CUR:   nxt_rdata = decel_cur_ff;
				ADDR_CRUISE_CUR:  nxt_rdata = cruise_cur_ff;
				default:          nxt_addr_err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_ff  <= 16'h0000;
			reg_rvalid_ff <= 1'b0;
		end else begin
			reg_rvalid_ff <= reg_rd;
			if (reg_rd)
				reg_rdata_ff <= nxt_rdata;
		end
	end

	// writes to the phase address are dropped and flagged unmapped
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			reg_addr_err_ff <= 1'b0;
		else
			reg_addr_err_ff <= (reg_rd && nxt_addr_err) ||
				(reg_wr && (nxt_addr_err || reg_addr == ADDR_ROTOR_PHASE));
	end

	// speed limiter sees resolution and morphing
	assign spd.req_pps  = speed_req_in;
	assign spd.res_code = resolution_ff;
	assign spd.morph_en = morph_ff[0];
	assign speed_lim_pps  = spd.lim_pps_ff;
	assign speed_too_slow = spd.too_slow_ff;
	assign speed_too_fast = spd.too_fast_ff;

	speed_limiter u_limiter (
		.clk   (clk),
		.rst_n (rst_n_i),
		.spd   (spd.limiter)
	);

	// selected sensor level; interrupt declaration stays with the program
	sensor_sync #(.WIDTH(SENSORS)) u_sensors (
		.clk       (clk),
		.rst_n     (rst_n_i),
		.pins      (sensor_pins),
		.levels_ff (sensor_levels)
	);

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i)
			sensor_level_ff <= 1'b0;
		else
			sensor_level_ff <= sensor_levels[sensor_sel_ff];
	end

	chk_phase_read: assert property (@(posedge clk) disable iff (!rst_n_i)
		(reg_rd && !reg_coil && reg_addr == ADDR_ROTOR_PHASE)
		|=> reg_rvalid_ff && reg_rdata_ff == $past(rotor_phase_in))
		else $error("phase read wrong");
	chk_res_refused: assert property (@(posedge clk) disable iff (!rst_n_i)
		(wr_word && reg_addr == ADDR_RESOLUTION && reg_wdata == RES_INVALID)
		|=> data_error_ff && $stable(resolution_ff))
		else $error("invalid resolution accepted");
	chk_res_legal: assert property (@(posedge clk) disable iff (!rst_n_i)
		res_reg_ff != RES_INVALID && res_reg_ff <= RES_MAX)
		else $error("resolution code illegal");
	chk_sense_coil: assert property (@(posedge clk) disable iff (!rst_n_i)
		(wr_bit && reg_addr == ADDR_SENSE)
		|=> forward_ff == $past(reg_wdata[0]) && sense_ff[15:1] == $past(sense_ff[15:1]))
		else $error("sense coil write wrong");
	chk_thr_halves: assert property (@(posedge clk) disable iff (!rst_n_i)
		(wr_word && reg_addr == ADDR_FS_THR_HI)
		|=> fs_threshold_ff[31:16] == $past(reg_wdata) && $stable(fs_threshold_ff[15:0]))
		else $error("threshold high half wrong");
	chk_fullstep_on: assert property (@(posedge clk) disable iff (!rst_n_i)
		(morph_ff[0] && speed_fs_in >= fs_threshold_ff) |=> fullstep_mode_ff)
		else $error("full-step not entered");
	chk_morph_off: assert property (@(posedge clk) disable iff (!rst_n_i)
		(!morph_ff[0]) [*2] |-> !fullstep_mode_ff && !torque_boost_ff)
		else $error("microstep not held with morphing off");
	chk_goal_low: assert property (@(posedge clk) disable iff (!rst_n_i)
		(wr_word && reg_addr == ADDR_GOAL_LO)
		|=> goal_pos_ff[15:0] == $past(reg_wdata)
			&& goal_pos_ff[31:16] == $past(goal_pos_ff[31:16]))
		else $error("goal low half wrong");
	chk_order_write: assert property (@(posedge clk) disable iff (!rst_n_i)
		(wr_word && reg_addr == ADDR_ORDER) |=> motion_order_ff == $past(reg_wdata))
		else $error("order not stored");
	chk_sensor_range: assert property (@(posedge clk) disable iff (!rst_n_i)
		sensor_reg_ff <= SENSOR_MAX)
		else $error("sensor selection out of range");
	chk_accel_range: assert property (@(posedge clk) disable iff (!rst_n_i)
		accel_cur_ff >= CUR_MIN_MA && accel_cur_ff <= CUR_MAX_MA)
		else $error("accel current out of range");
	chk_decel_range: assert property (@(posedge clk) disable iff (!rst_n_i)
		decel_cur_ff >= CUR_MIN_MA && decel_cur_ff <= CUR_MAX_MA)
		else $error("decel current out of range");
	chk_cruise_range: assert property (@(posedge clk) disable iff (!rst_n_i)
		(wr_word && reg_addr == ADDR_CRUISE_CUR && !cur_ok)
		|=> data_error_ff && $stable(cruise_cur_ff))
		else $error("cruise current write not refused");

	cover_fullstep_entry: cover property (@(posedge clk) disable iff (!rst_n_i)
		!fullstep_mode_ff ##1 fullstep_mode_ff);
	cover_bad_resolution: cover property (@(posedge clk) disable iff (!rst_n_i)
		data_error_ff);
	cover_morph_coil: cover property (@(posedge clk) disable iff (!rst_n_i)
		wr_bit && reg_addr == ADDR_MORPH);
endmodule

// ===== include/speed_if.sv
// speed request and limited speed between control and limiter
`timescale 1ns/1ns
interface speed_if;
	logic [31:0] req_pps;
	logic [3:0]  res_code;
	logic        morph_en;
	logic [31:0] lim_pps_ff;
	logic        too_slow_ff;
	logic        too_fast_ff;

	modport ctrl (output req_pps, output res_code, output morph_en,
		input lim_pps_ff, input too_slow_ff, input too_fast_ff);
	modport limiter (input req_pps, input res_code, input morph_en,
		output lim_pps_ff, output too_slow_ff, output too_fast_ff);
endinterface

// ===== include/stepper_regs_pkg.sv
// register map, field values and limits of the stepper parameter registers
package stepper_regs_pkg;

	// word addresses; 32-bit values take base (low half) and base+1 (high half)
	localparam logic [15:0] ADDR_ROTOR_PHASE  = 16'h5008;
	localparam logic [15:0] ADDR_RESOLUTION   = 16'h5009;
	localparam logic [15:0] ADDR_SENSE        = 16'h500a;
	localparam logic [15:0] ADDR_FS_THR_LO    = 16'h500b;
	localparam logic [15:0] ADDR_FS_THR_HI    = 16'h500c;
	localparam logic [15:0] ADDR_MORPH        = 16'h500d;
	localparam logic [15:0] ADDR_GOAL_LO      = 16'h500e;
	localparam logic [15:0] ADDR_GOAL_HI      = 16'h500f;
	localparam logic [15:0] ADDR_ORDER        = 16'h5010;
	localparam logic [15:0] ADDR_SENSOR_SEL   = 16'h5011;
	localparam logic [15:0] ADDR_ACCEL_CUR    = 16'h5012;
	localparam logic [15:0] ADDR_DECEL_CUR    = 16'h5013;
	localparam logic [15:0] ADDR_CRUISE_CUR   = 16'h5014;

	// resolution codes and sensor selection limit
	localparam logic [15:0] RES_INVALID       = 16'h0006;
	localparam logic [15:0] RES_MAX           = 16'h0008;
	localparam logic [15:0] SENSOR_MAX        = 16'h0007;

	// phase current window in mA
	localparam logic [15:0] CUR_MIN_MA        = 16'h0096;
	localparam logic [15:0] CUR_MAX_MA        = 16'h05dc;

	// commanded speed window in pulses per second
	localparam logic [31:0] SPEED_MIN_PPS     = 32'h0000_0008;
	localparam logic [31:0] SPEED_MAX_PPS     = 32'h0001_d4c0;

	// values after reset
	localparam logic [15:0] RST_RESOLUTION    = 16'h0000;
	localparam logic [15:0] RST_SENSE         = 16'h0001;
	localparam logic [31:0] RST_FS_THR        = 32'h0000_0000;
	localparam logic [15:0] RST_MORPH         = 16'h0000;
	localparam logic [31:0] RST_GOAL          = 32'h0000_0000;
	localparam logic [15:0] RST_ORDER         = 16'h0000;
	localparam logic [15:0] RST_SENSOR_SEL    = 16'h0000;
	localparam logic [15:0] RST_CURRENT       = 16'h0096;

	// motion phase codes from the motion engine
	localparam logic [1:0]  PHASE_ACCEL       = 2'h0;
	localparam logic [1:0]  PHASE_DECEL       = 2'h1;
	localparam logic [1:0]  PHASE_CRUISE      = 2'h2;

	typedef logic [3:0] res_code_t;

endpackage

// ===== verif/motor_stage_model.sv
// rotor stage model: microstep phase of the rotor against the stator
`timescale 1ns/1ns
module motor_stage_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// drive commands
	input  wire logic        run,
	input  wire logic        forward,
	// rotor feedback
	output logic      [15:0] rotor_phase_ff
);
	// direction sets step sign
	// wraps at four full steps of the finest division, so the phase never leaves that span
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rotor_phase_ff <= 16'h0000;
		end else if (run) begin
			rotor_phase_ff <= (forward ? rotor_phase_ff + 16'h0001 : rotor_phase_ff - 16'h0001)
				& 16'h03ff;
		end
	end
endmodule

// ===== verif/stepper_driver_param_regs_tb_top.sv
// self-checking bench of the stepper parameter registers
`timescale 1ns/1ns
`define CHK(a, e) begin \
	n_checks++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("Error %0t: got %h exp %h", $time, (a), (e)); \
	end \
end
module stepper_driver_param_regs_tb_top
	import stepper_regs_pkg::*;
;
	logic        clk, rst_n, reg_coil, reg_wr, reg_rd, run, bad;
	logic        reg_rvalid_ff, reg_addr_err_ff, data_error_ff, ae_v, de_v, rv_v;
	logic        forward_ff, fullstep_mode_ff, torque_boost_ff, sensor_level_ff;
	logic        speed_too_slow, speed_too_fast;
	logic [15:0] reg_addr, reg_wdata, reg_rdata_ff, rotor_phase_in, motion_order_ff;
	logic [15:0] phase_current_ff, rd_v;
	logic [31:0] speed_fs_in, speed_req_in, fs_threshold_ff, goal_pos_ff, speed_lim_pps;
	logic [1:0]  motion_phase_in;
	logic [3:0]  resolution_ff, prev;
	logic [2:0]  sensor_sel_ff;
	logic [7:0]  sensor_pins;
	logic [15:0] cur_v [4] = '{16'h0095, 16'h0096, 16'h05dc, 16'h05dd};
	int          bad_count = 0;
	int          n_checks = 0;

	stepper_param_regs #(.SENSORS(8)) uut (.clk, .rst_n, .reg_addr, .reg_coil, .reg_wr,
		.reg_wdata, .reg_rd, .reg_rdata_ff, .reg_rvalid_ff, .reg_addr_err_ff, .data_error_ff,
		.rotor_phase_in, .speed_fs_in, .speed_req_in, .motion_phase_in, .resolution_ff,
		.forward_ff, .fs_threshold_ff, .fullstep_mode_ff, .torque_boost_ff, .goal_pos_ff,
		.motion_order_ff, .sensor_sel_ff, .phase_current_ff, .speed_lim_pps, .speed_too_slow,
		.speed_too_fast, .sensor_pins, .sensor_level_ff);

	motor_stage_model stage (.clk, .rst_n, .run, .forward(forward_ff),
		.rotor_phase_ff(rotor_phase_in));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	// one access; results sampled once the answering edge has landed
	task automatic acc(input logic [15:0] a, input logic [15:0] d, input logic w,
		input logic c);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_coil = c;
		reg_wr = w;
		reg_rd = ~w;
		@(negedge clk);
		rd_v = reg_rdata_ff;
		ae_v = reg_addr_err_ff;
		de_v = data_error_ff;
		rv_v = reg_rvalid_ff;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask

	task automatic spd(input logic [31:0] q, input logic [31:0] e, input logic s,
		input logic f);
		@(negedge clk);
		speed_req_in = q;
		@(negedge clk);
		`CHK(speed_lim_pps, e)
		`CHK({speed_too_slow, speed_too_fast}, {s, f})
	endtask

	task automatic spin(input int n);
		@(negedge clk);
		run = 1'b1;
		repeat (n) @(negedge clk);
		run = 1'b0;
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		give_verdict();
	end

	initial begin
		rst_n = 1'b0;
		run = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_coil = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		speed_fs_in = 32'h0000_0000;
		speed_req_in = 32'h0000_0064;
		motion_phase_in = 2'h0;
		sensor_pins = 8'h00;
		prev = 4'h0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		spin(4);
		acc(ADDR_ROTOR_PHASE, 16'h0000, 1'b0, 1'b0);
		`CHK({rv_v, rd_v}, {1'b1, 16'h0004})
		acc(ADDR_ROTOR_PHASE, 16'h0055, 1'b1, 1'b0);
		`CHK({ae_v, rv_v}, 2'b10)
		acc(ADDR_SENSE, 16'h8000, 1'b1, 1'b0);
		`CHK(forward_ff, 1'b0)
		spin(5);
		acc(ADDR_ROTOR_PHASE, 16'h0000, 1'b0, 1'b0);
		`CHK(rd_v, 16'h03ff)
		acc(ADDR_SENSE, 16'h0001, 1'b1, 1'b1);
		`CHK(forward_ff, 1'b1)
		acc(ADDR_SENSE, 16'h0000, 1'b0, 1'b0);
		`CHK(rd_v, 16'h8001)
		acc(ADDR_SENSE, 16'h0000, 1'b0, 1'b1);
		`CHK(rd_v, 16'h0001)
		acc(ADDR_RESOLUTION, 16'h0000, 1'b0, 1'b1);
		`CHK(ae_v, 1'b1)
		for (int k = 0; k < 10; k++) begin
			acc(ADDR_RESOLUTION, 16'(k), 1'b1, 1'b0);
			bad = (k == 6) || (k > 8);
			if (!bad) prev = 4'(k);
			`CHK({de_v, resolution_ff}, {bad, prev})
		end
		spd(32'h0000_0004, SPEED_MIN_PPS, 1'b1, 1'b0);
		spd(32'h0001_d4c1, SPEED_MAX_PPS, 1'b0, 1'b1);
		spd(32'h0001_d4c0, SPEED_MAX_PPS, 1'b0, 1'b0);
		acc(ADDR_FS_THR_LO, 16'h0064, 1'b1, 1'b0);
		acc(ADDR_FS_THR_HI, 16'h0001, 1'b1, 1'b0);
		`CHK(fs_threshold_ff, 32'h0001_0064)
		speed_fs_in = 32'h0001_0063;
		acc(ADDR_MORPH, 16'h0001, 1'b1, 1'b0);
		@(negedge clk);
		`CHK({fullstep_mode_ff, torque_boost_ff}, 2'b01)
		speed_fs_in = 32'h0001_0064;
		@(negedge clk);
		`CHK(fullstep_mode_ff, 1'b1)
		spd(32'h0003_0d40, 32'h0003_0d40, 1'b0, 1'b0);
		spd(32'hffff_ffff, SPEED_MAX_PPS << 8, 1'b0, 1'b1);
		acc(ADDR_MORPH, 16'h0000, 1'b1, 1'b1);
		@(negedge clk);
		`CHK({fullstep_mode_ff, torque_boost_ff}, 2'b00)
		spd(32'h0003_0d40, SPEED_MAX_PPS, 1'b0, 1'b1);
		acc(ADDR_GOAL_LO, 16'h5678, 1'b1, 1'b0);
		acc(ADDR_GOAL_HI, 16'h1234, 1'b1, 1'b0);
		`CHK(goal_pos_ff, 32'h1234_5678)
		acc(ADDR_GOAL_HI, 16'h0000, 1'b0, 1'b0);
		`CHK(rd_v, 16'h1234)
		acc(ADDR_ORDER, 16'hbeef, 1'b1, 1'b0);
		acc(ADDR_ORDER, 16'h0000, 1'b0, 1'b0);
		`CHK({motion_order_ff, rd_v}, {16'hbeef, 16'hbeef})
		acc(ADDR_SENSOR_SEL, 16'h0003, 1'b1, 1'b0);
		acc(ADDR_SENSOR_SEL, 16'h0008, 1'b1, 1'b0);
		`CHK({de_v, sensor_sel_ff}, {1'b1, 3'h3})
		// program owns the interrupt for input 3
		sensor_pins = 8'h08;
		repeat (6) @(negedge clk);
		`CHK(sensor_level_ff, 1'b1)
		sensor_pins = 8'hf7;
		repeat (6) @(negedge clk);
		`CHK(sensor_level_ff, 1'b0)
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 4; j++) begin
				acc(ADDR_ACCEL_CUR + 16'(i), cur_v[j], 1'b1, 1'b0);
				`CHK(de_v, 1'(j == 0 || j == 3))
				acc(ADDR_ACCEL_CUR + 16'(i), 16'h0000, 1'b0, 1'b0);
				`CHK(rd_v, (j < 2) ? CUR_MIN_MA : CUR_MAX_MA)
			end
			acc(ADDR_ACCEL_CUR + 16'(i), 16'h00c8 + 16'(i) * 16'h0064, 1'b1, 1'b0);
		end
		for (int m = 0; m < 4; m++) begin
			motion_phase_in = 2'(m);
			@(negedge clk);
			`CHK(phase_current_ff, (m > 2) ? 16'h0190 : 16'h00c8 + 16'(m) * 16'h0064)
		end
		acc(16'h5020, 16'h0000, 1'b0, 1'b0);
		`CHK({ae_v, rd_v}, {1'b1, 16'h0000})
		give_verdict();
	end
endmodule
